// ---- core/huwl_pkg.sv ----
package huwl_pkg;
	// ----------------------------------------------------------------
	// Clock, rates and divisors
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 100_000_000;
	localparam int BAUD_115K = 115200;
	localparam int BAUD_921K = 921600;
	localparam int BAUD_1M5 = 1500000;
	localparam int BAUD_3M = 3000000;
	localparam logic [15:0] DIV_115K = 16'(CLK_HZ / BAUD_115K);
	localparam logic [15:0] DIV_921K = 16'(CLK_HZ / BAUD_921K);
	localparam logic [15:0] DIV_1M5 = 16'(CLK_HZ / BAUD_1M5);
	localparam logic [15:0] DIV_3M = 16'(CLK_HZ / BAUD_3M);
	localparam logic [15:0] DIV_MIN = DIV_3M;
	localparam logic [15:0] RST_DIV = DIV_115K;
	// ----------------------------------------------------------------
	// Buffers and framing
	// ----------------------------------------------------------------
	localparam int HCI_FIFO = 1040;
	localparam int PERI_FIFO = 256;
	localparam int RTS_MARGIN = 16;
	localparam logic [3:0] CHAR_BITS = 4'hA;
	localparam logic [7:0] H4_CMD = 8'h01;
	localparam logic [7:0] H4_ACL = 8'h02;
	localparam logic [7:0] H4_SCO = 8'h03;
	localparam logic [7:0] H4_EVT = 8'h04;
	localparam logic RST_TXD = 1'b1;
	localparam logic RST_RTS_N = 1'b1;
	localparam logic RST_HOST_WAKE = 1'b0;

	typedef enum logic [1:0] {
		HUWL_B115K, HUWL_B921K, HUWL_B1M5, HUWL_B3M
	} huwl_baud_e;

	typedef struct packed {
		logic use_custom;
		huwl_baud_e sel;
		logic [15:0] custom_div;
	} huwl_cfg_s;

	typedef struct packed {
		logic sop;
		logic bad;
		logic [7:0] data;
	} huwl_rx_s;

	function automatic logic [15:0] huwl_div(input huwl_cfg_s c);
		logic [15:0] d;
		case (c.sel)
			HUWL_B921K: d = DIV_921K;
			HUWL_B1M5: d = DIV_1M5;
			HUWL_B3M: d = DIV_3M;
			default: d = DIV_115K;
		endcase
		// Custom divisors outside the supported rate span fall back
		if (c.use_custom && c.custom_div >= DIV_MIN &&
			c.custom_div <= DIV_115K) begin
			d = c.custom_div;
		end
		return d;
	endfunction : huwl_div
endpackage : huwl_pkg

// ---- core/huwl_uart.sv ----
`timescale 1ns/1ps

// --------------------------------------------------------------------
// FIFO of W-bit words with registered flags
// --------------------------------------------------------------------
module huwl_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 1040
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	output logic [$clog2(DEPTH+1)-1:0] level
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r, rd_r;
	logic [CW-1:0] cnt_r, cnt_nxt;
	wire push = in_valid & in_ready;
	wire pop = out_valid & out_ready;
	assign cnt_nxt = cnt_r + CW'(push) - CW'(pop);
	assign out_data = mem[rd_r];
	assign level = cnt_r;
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_r] <= in_data;
		end
	end
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			if (pop) rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			cnt_r <= cnt_nxt;
			in_ready <= cnt_nxt != CW'(DEPTH);
			out_valid <= cnt_nxt != '0;
		end
	end
endmodule : huwl_fifo

// --------------------------------------------------------------------
// UART top
// --------------------------------------------------------------------
module huwl_uart #(
	parameter int FIFO_DEPTH = huwl_pkg::HCI_FIFO
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic uart_rxd,
	output logic uart_txd,
	input wire logic cts_n,
	output logic rts_n,
	input wire huwl_pkg::huwl_cfg_s cfg,
	input wire logic cfg_load,
	input wire logic wake_enable,
	input wire logic device_wake_request,
	output logic host_wake,
	output logic device_awake,
	input wire logic tx_valid,
	input wire logic [7:0] tx_data,
	output logic tx_ready,
	output logic rx_valid,
	output huwl_pkg::huwl_rx_s rx_word,
	input wire logic rx_ready
);
	import huwl_pkg::*;
	localparam int CW = $clog2(FIFO_DEPTH+1);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} huwl_rx_e;
	typedef enum logic [2:0] {
		H4_IND, H4_HDR, H4_LEN_LO, H4_LEN_HI, H4_PAY
	} huwl_h4_e;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	// ----------------------------------------------------------------
	// Rate select
	// ----------------------------------------------------------------
	// Engines latch the divisor only at a character start, so a change
	// never splits a character.
	logic [15:0] div_r;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) div_r <= RST_DIV;
		else if (cfg_load) div_r <= huwl_div(cfg);
	end

	// ----------------------------------------------------------------
	// Transmit
	// ----------------------------------------------------------------
	logic tf_valid, tx_busy_r;
	logic [7:0] tf_data;
	logic [9:0] tx_sh_r;
	logic [3:0] tx_left_r;
	logic [15:0] tx_cnt_r, tx_div_r;
	logic [CW-1:0] rf_level;
	wire tx_start = !tx_busy_r && tf_valid && !cts_n;
	wire tx_tick = tx_busy_r && tx_cnt_r == 16'h0001;

	huwl_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_txf (
		.core_clk(core_clk), .nrst(nrst),
		.in_valid(tx_valid), .in_data(tx_data), .in_ready(tx_ready),
		.out_valid(tf_valid), .out_data(tf_data), .out_ready(tx_start),
		.level()
	);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			tx_busy_r <= 1'b0;
			tx_sh_r <= '1;
			tx_left_r <= '0;
			tx_cnt_r <= '0;
			tx_div_r <= RST_DIV;
			uart_txd <= RST_TXD;
		end else if (tx_start) begin
			tx_busy_r <= 1'b1;
			tx_sh_r <= {1'b1, tf_data, 1'b0};
			tx_left_r <= CHAR_BITS;
			tx_cnt_r <= div_r;
			tx_div_r <= div_r;
			uart_txd <= 1'b0;
		end else if (tx_busy_r) begin
			tx_cnt_r <= tx_tick ? tx_div_r : tx_cnt_r - 1'b1;
			if (tx_tick) begin
				tx_sh_r <= {1'b1, tx_sh_r[9:1]};
				tx_left_r <= tx_left_r - 1'b1;
				tx_busy_r <= tx_left_r != 4'h1;
				uart_txd <= tx_sh_r[1];
			end
		end
	end

	// ----------------------------------------------------------------
	// Receive
	// ----------------------------------------------------------------
	huwl_rx_e rx_st_r;
	logic [15:0] rx_cnt_r, rx_div_r;
	logic [2:0] rx_bit_r;
	logic [7:0] rx_sh_r;
	logic rx_done_r, rf_in_ready;
	wire rx_tick = rx_cnt_r == 16'h0000;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rx_st_r <= RX_IDLE;
			rx_cnt_r <= '0;
			rx_div_r <= RST_DIV;
			rx_bit_r <= '0;
			rx_sh_r <= '0;
			rx_done_r <= 1'b0;
		end else begin
			rx_done_r <= 1'b0;
			rx_cnt_r <= rx_tick ? rx_div_r - 1'b1 : rx_cnt_r - 1'b1;
			case (rx_st_r)
				RX_IDLE: if (!uart_rxd) begin
					rx_st_r <= RX_START;
					rx_div_r <= div_r;
					rx_cnt_r <= {1'b0, div_r[15:1]};
				end
				RX_START: if (rx_tick) begin
					rx_st_r <= uart_rxd ? RX_IDLE : RX_DATA;
					rx_bit_r <= '0;
				end
				RX_DATA: if (rx_tick) begin
					rx_sh_r <= {uart_rxd, rx_sh_r[7:1]};
					rx_bit_r <= rx_bit_r + 1'b1;
					if (rx_bit_r == 3'h7) rx_st_r <= RX_STOP;
				end
				RX_STOP: if (rx_tick) begin
					// Bad stop bit drops the character
					rx_done_r <= uart_rxd;
					rx_st_r <= RX_IDLE;
				end
				default: rx_st_r <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// H4 packet tracking
	// ----------------------------------------------------------------
	huwl_h4_e h4_r;
	logic [15:0] h4_left_r;
	logic h4_acl_r;
	wire ind_ok = rx_sh_r inside {H4_CMD, H4_ACL, H4_SCO, H4_EVT};
	wire [15:0] len_lo = {8'h00, rx_sh_r};
	huwl_rx_s rx_in;
	assign rx_in = '{sop: h4_r == H4_IND, bad: h4_r == H4_IND && !ind_ok,
		data: rx_sh_r};
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			h4_r <= H4_IND;
			h4_left_r <= '0;
			h4_acl_r <= 1'b0;
		end else if (rx_done_r) begin
			case (h4_r)
				H4_IND: if (ind_ok) begin
					h4_acl_r <= rx_sh_r == H4_ACL;
					h4_left_r <= rx_sh_r == H4_EVT ? 16'h0001 : 16'h0002;
					h4_r <= H4_HDR;
				end
				H4_HDR: begin
					h4_left_r <= h4_left_r - 1'b1;
					if (h4_left_r == 16'h0001) h4_r <= H4_LEN_LO;
				end
				H4_LEN_LO: begin
					h4_left_r <= len_lo;
					h4_r <= h4_acl_r ? H4_LEN_HI :
						(len_lo == '0 ? H4_IND : H4_PAY);
				end
				H4_LEN_HI: begin
					h4_left_r <= {rx_sh_r, h4_left_r[7:0]};
					h4_r <= {rx_sh_r, h4_left_r[7:0]} == '0 ? H4_IND : H4_PAY;
				end
				H4_PAY: begin
					h4_left_r <= h4_left_r - 1'b1;
					if (h4_left_r == 16'h0001) h4_r <= H4_IND;
				end
				default: h4_r <= H4_IND;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Receive FIFO and two-entry output buffer
	// ----------------------------------------------------------------
	logic rf_valid, sk_v1_r;
	huwl_rx_s rf_data, sk_b1_r;
	wire sk_push = rf_valid && !sk_v1_r;
	wire sk_take = rx_valid && rx_ready;
	huwl_fifo #(.W($bits(huwl_rx_s)), .DEPTH(FIFO_DEPTH)) u_rxf (
		.core_clk(core_clk), .nrst(nrst),
		.in_valid(rx_done_r), .in_data(rx_in), .in_ready(rf_in_ready),
		.out_valid(rf_valid), .out_data(rf_data), .out_ready(sk_push),
		.level(rf_level)
	);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rx_valid <= 1'b0;
			sk_v1_r <= 1'b0;
			rx_word <= '0;
			sk_b1_r <= '0;
		end else begin
			case ({sk_push, sk_take})
				2'b10: if (!rx_valid) begin
					rx_word <= rf_data;
					rx_valid <= 1'b1;
				end else begin
					sk_b1_r <= rf_data;
					sk_v1_r <= 1'b1;
				end
				2'b01: begin
					rx_word <= sk_b1_r;
					rx_valid <= sk_v1_r;
					sk_v1_r <= 1'b0;
				end
				2'b11: if (sk_v1_r) begin
					rx_word <= sk_b1_r;
					sk_b1_r <= rf_data;
				end else begin
					rx_word <= rf_data;
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Flow control and wake lines
	// ----------------------------------------------------------------
	// Margin leaves room for characters already in flight at the host.
	wire near_full = rf_level >= CW'(FIFO_DEPTH - RTS_MARGIN);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			rts_n <= RST_RTS_N;
			host_wake <= RST_HOST_WAKE;
			device_awake <= 1'b1;
		end else begin
			rts_n <= near_full;
			host_wake <= wake_enable && (rf_valid || rx_valid);
			device_awake <= !wake_enable || device_wake_request;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_tx_begin;
		!tx_busy_r ##1 tx_busy_r;
	endsequence
	sequence s_start_bit;
		!uart_txd [*2];
	endsequence
	tx_cts_gate_a: assert property (s_tx_begin |-> $past(!cts_n))
		else $error("character started while CTS deasserted");
	tx_start_low_a: assert property ($rose(tx_busy_r) |-> s_start_bit)
		else $error("start bit not low");
	tx_idle_high_a: assert property (!tx_busy_r |-> uart_txd)
		else $error("line not idle high");
	tx_stop_high_a: assert property (tx_busy_r && tx_left_r == 4'h1 |->
		uart_txd)
		else $error("stop bit not high");
	rts_near_full_a: assert property (near_full |=> rts_n)
		else $error("RTS asserted near full");
	wake_gated_a: assert property (!wake_enable |=> !host_wake)
		else $error("host wake active while disabled");
	wake_pending_a: assert property (wake_enable && rx_valid |=>
		host_wake)
		else $error("host wake missing with data pending");
	rate_default_a: assert property (!cfg_load [*2] |-> $stable(div_r))
		else $error("divisor changed without load");
	rate_range_a: assert property (div_r >= DIV_MIN &&
		div_r <= RST_DIV)
		else $error("divisor outside supported range");
	rx_no_loss_a: assert property (rx_done_r |-> rf_in_ready)
		else $error("receive FIFO overflow");
endmodule : huwl_uart

// ---- tb/huwl_host_model.sv ----
`timescale 1ns/1ps
// ------
// Host side serial model
// ------
module huwl_host_model (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic uart_txd,
	output logic uart_rxd,
	output logic cts_n
);
	// No RTS input: host leaves that pin open
	logic hold = 1'b0;
	initial uart_rxd = 1'b1;
	// Held off through reset, released once running
	assign cts_n = !nrst || hold;
	// 8N1 LSB first on the receive wire, idle high
	task automatic send(input logic [7:0] v, input int d, input int gap);
		logic [9:0] f;
		f = {1'b1, v, 1'b0};
		repeat (gap) @(negedge core_clk);
		for (int i = 0; i < 10; i++) begin
			@(negedge core_clk);
			uart_rxd = f[i];
			repeat (d - 1) @(negedge core_clk);
		end
	endtask : send
	// Midpoint sampling; gives up after forty bit times
	task automatic recv(input int d, output logic [7:0] v, output logic ok);
		int n;
		n = 0;
		// Falling edges, so each read sees a settled line
		while (uart_txd !== 1'b0 && n < 40 * d) begin
			@(negedge core_clk);
			n++;
		end
		repeat (d / 2) @(negedge core_clk);
		ok = (uart_txd === 1'b0) && (n < 40 * d);
		for (int i = 0; i < 8; i++) begin
			repeat (d) @(negedge core_clk);
			v[i] = uart_txd;
		end
		repeat (d) @(negedge core_clk);
		ok = ok && (uart_txd === 1'b1);
	endtask : recv
endmodule : huwl_host_model

// ---- tb/tb_hci_uart_with_wake_lines.sv ----
`timescale 1ns/1ps
module tb_hci_uart_with_wake_lines;
	import huwl_pkg::*;
	// Small FIFO keeps fill runs short; the RTS margin still applies
	localparam int DEPTH = 32;
	localparam int LIMIT = 100000;
	localparam logic [7:0] H4 [9] = '{8'h04, 8'h0E, 8'h01, 8'hAA, 8'h07,
		8'h03, 8'h12, 8'h34, 8'h00};
	localparam logic [8:0] SOP = 9'h031;
	localparam logic [8:0] BAD = 9'h010;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic uart_rxd, uart_txd, cts_n, rts_n, host_wake, device_awake;
	huwl_cfg_s cfg = '0;
	logic cfg_load = 1'b0;
	logic wake_enable = 1'b0;
	logic device_wake_request = 1'b0;
	logic tx_valid = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_ready, rx_valid;
	logic rx_ready = 1'b0;
	huwl_rx_s rx_word, w;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	int d, k;
	logic [7:0] b, g;
	logic ok;
	logic [7:0] q[$];

	always #5 core_clk = !core_clk;

	huwl_uart #(.FIFO_DEPTH(DEPTH)) u_huwl_uart (.core_clk(core_clk),
		.nrst(nrst), .uart_rxd(uart_rxd), .uart_txd(uart_txd),
		.cts_n(cts_n), .rts_n(rts_n), .cfg(cfg), .cfg_load(cfg_load),
		.wake_enable(wake_enable), .device_wake_request(device_wake_request),
		.host_wake(host_wake), .device_awake(device_awake),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
		.rx_valid(rx_valid), .rx_word(rx_word), .rx_ready(rx_ready));
	huwl_host_model u_huwl_host_model (.core_clk(core_clk), .nrst(nrst),
		.uart_txd(uart_txd), .uart_rxd(uart_rxd), .cts_n(cts_n));

	// ------
	// Checks and drivers
	// ------
	task automatic note(input logic ok_i, input logic [15:0] got,
		input logic [15:0] exp);
		n_tests++;
		if (!ok_i) begin
			miscompares++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : note
	task automatic chk_flag(input logic got, input logic exp);
		note(got === exp, 16'(got), 16'(exp));
	endtask : chk_flag
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		note(got === exp, 16'(got), 16'(exp));
	endtask : chk_byte
	task automatic chk_word(input huwl_rx_s got, input huwl_rx_s exp);
		note(got === exp, 16'(got), 16'(exp));
	endtask : chk_word
	function automatic int exp_div(input logic u, input huwl_baud_e s,
		input logic [15:0] c);
		int r;
		r = (s == HUWL_B921K) ? BAUD_921K : (s == HUWL_B1M5) ? BAUD_1M5 :
			(s == HUWL_B3M) ? BAUD_3M : BAUD_115K;
		if (u && c >= 16'(CLK_HZ / BAUD_3M) &&
			c <= 16'(CLK_HZ / BAUD_115K)) begin
			return int'(c);
		end
		return CLK_HZ / r;
	endfunction : exp_div
	task automatic set_cfg(input logic u, input huwl_baud_e s,
		input logic [15:0] c);
		@(negedge core_clk);
		cfg = '{u, s, c};
		cfg_load = 1'b1;
		@(negedge core_clk);
		cfg_load = 1'b0;
		d = exp_div(u, s, c);
	endtask : set_cfg
	task automatic tx_put(input logic [7:0] v, output logic acc);
		int n;
		n = 0;
		@(negedge core_clk);
		tx_valid = 1'b1;
		tx_data = v;
		while (tx_ready !== 1'b1 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		acc = (tx_ready === 1'b1);
		@(negedge core_clk);
		tx_valid = 1'b0;
	endtask : tx_put
	task automatic rx_get(output huwl_rx_s v);
		int n;
		n = 0;
		@(negedge core_clk);
		rx_ready = 1'b1;
		while (rx_valid !== 1'b1 && n < 4000) begin
			@(negedge core_clk);
			n++;
		end
		if (rx_valid !== 1'b1) note(1'b0, 16'h0000, 16'h0001);
		v = rx_word;
		@(negedge core_clk);
		rx_ready = 1'b0;
	endtask : rx_get
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : summarize

	// Hang guard
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			miscompares++;
			summarize();
		end
	end

	// ------
	// Sequence
	// ------
	initial begin
		void'($urandom(96));
		repeat (2) @(negedge core_clk);
		chk_flag(uart_txd, RST_TXD);
		chk_flag(rts_n, RST_RTS_N);
		nrst = 1'b1;
		repeat (2) @(negedge core_clk);
		chk_flag(host_wake, 1'b0);
		chk_flag(device_awake, 1'b1);
		d = exp_div(1'b0, HUWL_B115K, 16'h0000);
		b = 8'($urandom);
		tx_put(b, ok);
		u_huwl_host_model.recv(d, g, ok);
		chk_flag(ok, 1'b1);
		chk_byte(g, b);
		u_huwl_host_model.send(H4[0], d, 0);
		// Rate switch lands inside a packet
		set_cfg(1'b0, HUWL_B3M, 16'h0000);
		for (k = 1; k < 9; k++) begin
			u_huwl_host_model.send(H4[k], d, $urandom_range(0, 20));
		end
		chk_flag(host_wake, 1'b0);
		for (k = 0; k < 9; k++) begin
			rx_get(w);
			chk_word(w, huwl_rx_s'{SOP[k], BAD[k], H4[k]});
		end
		$display("test default rate and framing finished");
		// Presets, then custom 50 taken, custom 20 and 900 refused
		for (k = 0; k < 7; k++) begin
			set_cfg(k > 3, huwl_baud_e'(k % 4),
				(k == 4) ? 16'h0032 : (k == 5) ? 16'h0014 : 16'h0384);
			b = 8'($urandom);
			tx_put(b, ok);
			u_huwl_host_model.recv(d, g, ok);
			chk_flag(ok, 1'b1);
			chk_byte(g, b);
			b = 8'($urandom);
			u_huwl_host_model.send(b, d + ((k % 2) ? d / 25 : -(d / 25)), 0);
			rx_get(w);
			chk_byte(w.data, b);
		end
		$display("test rates finished");
		set_cfg(1'b0, HUWL_B3M, 16'h0000);
		u_huwl_host_model.hold = 1'b1;
		q.delete();
		do begin
			b = 8'($urandom);
			tx_put(b, ok);
			if (ok) q.push_back(b);
		end while (ok && q.size() < DEPTH + 8);
		chk_flag(q.size() >= DEPTH && q.size() <= DEPTH + 3, 1'b1);
		u_huwl_host_model.recv(d, g, ok);
		chk_flag(ok, 1'b0);
		@(negedge core_clk);
		u_huwl_host_model.hold = 1'b0;
		foreach (q[i]) begin
			u_huwl_host_model.recv(d, g, ok);
			chk_byte(g, q[i]);
		end
		$display("test transmit fill finished");
		chk_flag(rts_n, 1'b0);
		q.delete();
		for (k = 0; k < DEPTH - 13; k++) begin
			b = 8'($urandom);
			q.push_back(b);
			u_huwl_host_model.send(b, d, 0);
		end
		chk_flag(rts_n, 1'b1);
		foreach (q[i]) begin
			rx_get(w);
			chk_byte(w.data, q[i]);
		end
		repeat (4) @(negedge core_clk);
		chk_flag(rts_n, 1'b0);
		$display("test receive fill finished");
		// Host drives the wake request
		wake_enable = 1'b1;
		repeat (3) @(negedge core_clk);
		chk_flag(device_awake, 1'b0);
		chk_flag(host_wake, 1'b0);
		device_wake_request = 1'b1;
		repeat (3) @(negedge core_clk);
		chk_flag(device_awake, 1'b1);
		u_huwl_host_model.send(b, d, 0);
		repeat (8) @(negedge core_clk);
		chk_flag(host_wake, 1'b1);
		rx_get(w);
		chk_byte(w.data, b);
		repeat (4) @(negedge core_clk);
		chk_flag(host_wake, 1'b0);
		$display("test wake lines finished");
		summarize();
	end
endmodule : tb_hci_uart_with_wake_lines
